/* include/acs_pkg.sv */
// constants and types for the converter sequencer
// Operation
// - periodic mode waits interval field times 40 us between cycles; zero means none
// - periodic start waits start field times 40 us before first cycle
// - one-shot cycle ignores both delay fields and starts at once
// - eight per-channel done flags set on completion, held until cleared
// - writing one clears a done flag, zero leaves it
// - one-shot done flag set after all enabled one-shot channels finish
// - periodic done flag set after all enabled periodic channels finish
// - one-shot mask selects channels converted in a one-shot cycle
// - periodic mask selects channels converted in each periodic pass
// - each channel result is a 32-bit register, low 10 bits, rest zero
// - result read in one 32-bit access is coherent
// - bits of unimplemented channels are reserved and inert
// - periodic run bit starts cycles; clearing lets running cycle finish
// - one-shot go bit starts one cycle from idle only, ignored in wait or conversion; clears itself
// - cycle start clears its own done flag
// - enable cleared lets running cycle finish, blocks new ones
package acs_pkg;
  localparam int NCH = 8;
  localparam int RES_W = 10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DELAY = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_ONESHOT = 8'h0C;
  localparam logic [7:0] OFS_PERIODIC = 8'h10;
  localparam logic [7:0] OFS_RES0 = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
  localparam int B_EN = 0;
  localparam int B_GO = 1;
  localparam int B_RUN = 2;
  localparam int B_PDONE = 6;
  localparam int B_ODONE = 7;
  localparam int IRQ_W = 10;
  localparam int IRQ_PDONE = 8;
  localparam int IRQ_ODONE = 9;
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 40;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acs_bus_t;
  typedef struct packed {
    logic start;
    logic [2:0] chan;
  } acs_conv_req_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_WAIT = 4'h2,
    S_CONV = 4'h4,
    S_BUSY = 4'h8
  } acs_state_t;
endpackage

/* rtl/acs_seq.sv */
// converter sequencer with register file and interrupt
`timescale 1ns/10ps
module acs_seq
  import acs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire acs_bus_t bus,
  output logic [31:0] rdata,
  output acs_conv_req_t conv_req,
  input wire logic conv_done,
  input wire logic [RES_W-1:0] conv_data,
  output logic irq
);
  logic rs1_r, rs_r;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs1_r <= 1'b0;
      rs_r <= 1'b0;
    end
    else
    begin
      rs1_r <= 1'b1;
      rs_r <= rs1_r;
    end
  end

  function automatic logic hit(input acs_bus_t b, input logic [7:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  logic en_r, en_nxt, run_r, run_nxt, odone_r, odone_nxt, pdone_r, pdone_nxt;
  logic [31:0] delay_r, delay_nxt;
  logic [7:0] flags_r, flags_nxt, omask_r, omask_nxt, pmask_r, pmask_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic [RES_W-1:0] res_r [NCH];
  logic [15:0] pre_r, pre_nxt, dcnt_r, dcnt_nxt;
  logic tick;
  logic oneshot_r, oneshot_nxt, first_r, first_nxt;
  logic [2:0] chan_r, chan_nxt;
  acs_state_t st_r, st_nxt;
  acs_conv_req_t req_nxt;
  logic [31:0] rd_nxt;
  logic irq_nxt;
  logic go_w, run_w, run_rise, odone_set, pdone_set, begin_o, begin_p;
  logic [7:0] ch_set;
  logic [2:0] nxt_ch;
  logic nxt_found;

  assign tick = (pre_r == 16'(TICK_CYCLES - 1));
  assign go_w = hit(bus, OFS_CTRL) && bus.wdata[B_GO] && bus.wdata[B_EN];
  assign run_w = hit(bus, OFS_CTRL) && bus.wdata[B_RUN];
  assign run_rise = run_w && !run_r;

  // next pending channel above current one
  always_comb
  begin
    nxt_ch = 3'h0;
    nxt_found = 1'b0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (pend_r[i] && (3'(i) > chan_r))
      begin
        nxt_ch = 3'(i);
        nxt_found = 1'b1;
      end
    end
  end

  function automatic logic [2:0] lowest(input logic [7:0] m);
    lowest = 3'h0;
    for (int i = NCH - 1; i >= 0; i--)
    begin
      if (m[i])
        lowest = 3'(i);
    end
  endfunction

  // sequencer
  always_comb
  begin
    st_nxt = st_r;
    pend_nxt = pend_r;
    chan_nxt = chan_r;
    oneshot_nxt = oneshot_r;
    first_nxt = first_r;
    dcnt_nxt = dcnt_r;
    pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
    req_nxt = '{start: 1'b0, chan: chan_r};
    odone_set = 1'b0;
    pdone_set = 1'b0;
    begin_o = 1'b0;
    begin_p = 1'b0;
    ch_set = 8'h00;
    case (st_r)
      S_IDLE:
      begin
        if (go_w)
        begin
          oneshot_nxt = 1'b1;
          pend_nxt = omask_r;
          begin_o = 1'b1;
          st_nxt = S_CONV;
        end
        else if (run_r && en_r)
        begin
          oneshot_nxt = 1'b0;
          dcnt_nxt = first_r ? delay_r[15:0] : delay_r[31:16];
          pre_nxt = 16'h0000;
          st_nxt = S_WAIT;
        end
      end
      S_WAIT:
      begin
        if (!run_r || !en_r)
          st_nxt = S_IDLE;
        else if (dcnt_r == 16'h0000)
        begin
          first_nxt = 1'b0;
          pend_nxt = pmask_r;
          begin_p = 1'b1;
          st_nxt = S_CONV;
        end
        else if (tick)
          dcnt_nxt = dcnt_r - 16'h0001;
      end
      S_CONV:
      begin
        if (pend_r == 8'h00)
        begin
          odone_set = oneshot_r;
          pdone_set = !oneshot_r;
          st_nxt = S_IDLE;
        end
        else
        begin
          chan_nxt = lowest(pend_r);
          req_nxt = '{start: 1'b1, chan: lowest(pend_r)};
          st_nxt = S_BUSY;
        end
      end
      S_BUSY:
      begin
        if (conv_done)
        begin
          ch_set[chan_r] = 1'b1;
          pend_nxt[chan_r] = 1'b0;
          if (nxt_found)
          begin
            chan_nxt = nxt_ch;
            req_nxt = '{start: 1'b1, chan: nxt_ch};
          end
          else
            st_nxt = S_CONV;
        end
      end
      default:
        st_nxt = S_IDLE;
    endcase
    if (run_rise)
      first_nxt = 1'b1;
  end

  // registers and flags
  always_comb
  begin
    en_nxt = en_r;
    run_nxt = run_r;
    delay_nxt = delay_r;
    omask_nxt = omask_r;
    pmask_nxt = pmask_r;
    imask_nxt = imask_r;
    flags_nxt = flags_r;
    odone_nxt = odone_r;
    pdone_nxt = pdone_r;
    if (hit(bus, OFS_CTRL))
    begin
      en_nxt = bus.wdata[B_EN];
      run_nxt = bus.wdata[B_RUN];
      if (bus.wdata[B_ODONE])
        odone_nxt = 1'b0;
      if (bus.wdata[B_PDONE])
        pdone_nxt = 1'b0;
    end
    if (hit(bus, OFS_DELAY))
      delay_nxt = bus.wdata;
    // only eight channels exist, upper bits dropped
    if (hit(bus, OFS_ONESHOT))
      omask_nxt = bus.wdata[7:0];
    if (hit(bus, OFS_PERIODIC))
      pmask_nxt = bus.wdata[7:0];
    if (hit(bus, OFS_IRQ_MASK))
      imask_nxt = bus.wdata[IRQ_W-1:0];
    if (hit(bus, OFS_FLAGS))
      flags_nxt = flags_r & ~bus.wdata[7:0];
    flags_nxt = flags_nxt | ch_set;
    // set beats clear; a cycle start clears its own done flag
    if (begin_o)
      odone_nxt = 1'b0;
    if (begin_p)
      pdone_nxt = 1'b0;
    if (odone_set)
      odone_nxt = 1'b1;
    if (pdone_set)
      pdone_nxt = 1'b1;
    irq_nxt = |({odone_nxt, pdone_nxt, flags_nxt} & imask_nxt);
  end

  // read mux; whole word captured in one cycle keeps results coherent
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (bus.rd)
    begin
      case (bus.addr)
        OFS_CTRL: rd_nxt = {24'h0, odone_r, pdone_r, 3'h0, run_r, 1'b0, en_r};
        OFS_DELAY: rd_nxt = delay_r;
        OFS_FLAGS: rd_nxt = {24'h0, flags_r};
        OFS_ONESHOT: rd_nxt = {24'h0, omask_r};
        OFS_PERIODIC: rd_nxt = {24'h0, pmask_r};
        OFS_IRQ_MASK: rd_nxt = {22'h0, imask_r};
        default:
        begin
          if (bus.addr >= OFS_RES0 && bus.addr < 8'(OFS_RES0 + 4 * NCH) && bus.addr[1:0] == 2'h0)
          begin
            rd_nxt = {22'h0, res_r[3'(8'(bus.addr - OFS_RES0) >> 2)]};
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rs_r)
  begin
    if (!rs_r)
    begin
      st_r <= S_IDLE;
      pend_r <= 8'h00;
      chan_r <= 3'h0;
      oneshot_r <= 1'b0;
      first_r <= 1'b0;
      dcnt_r <= 16'h0000;
      pre_r <= 16'h0000;
      conv_req <= '0;
      en_r <= 1'b0;
      run_r <= 1'b0;
      delay_r <= 32'h0000_0000;
      omask_r <= 8'h00;
      pmask_r <= 8'h00;
      imask_r <= '0;
      flags_r <= 8'h00;
      odone_r <= 1'b0;
      pdone_r <= 1'b0;
      rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      pend_r <= pend_nxt;
      chan_r <= chan_nxt;
      oneshot_r <= oneshot_nxt;
      first_r <= first_nxt;
      dcnt_r <= dcnt_nxt;
      pre_r <= pre_nxt;
      conv_req <= req_nxt;
      en_r <= en_nxt;
      run_r <= run_nxt;
      delay_r <= delay_nxt;
      omask_r <= omask_nxt;
      pmask_r <= pmask_nxt;
      imask_r <= imask_nxt;
      flags_r <= flags_nxt;
      odone_r <= odone_nxt;
      pdone_r <= pdone_nxt;
      rdata <= rd_nxt;
      irq <= irq_nxt;
    end
  end

  // result store, data only, no reset needed
  always_ff @(posedge mclk)
  begin
    if (st_r == S_BUSY && conv_done)
      res_r[chan_r] <= conv_data;
  end

  property p_flag_set;
    @(posedge mclk) disable iff (!rs_r) (st_r == S_BUSY && conv_done) |=> flags_r[$past(chan_r)];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");
  property p_w1c;
    @(posedge mclk) disable iff (!rs_r)
      (hit(bus, OFS_FLAGS) && bus.wdata[0] && !(st_r == S_BUSY && conv_done && chan_r == 3'h0))
      |=> !flags_r[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_w0;
    @(posedge mclk) disable iff (!rs_r) (hit(bus, OFS_FLAGS) && !bus.wdata[0] && flags_r[0])
      |=> flags_r[0];
  endproperty
  a_w0: assert property (p_w0) else $error("zero write cleared flag");
  property p_oneshot_now;
    @(posedge mclk) disable iff (!rs_r) (st_r == S_IDLE && go_w) |=> st_r == S_CONV;
  endproperty
  a_oneshot_now: assert property (p_oneshot_now) else $error("one-shot delayed");
  property p_odone;
    @(posedge mclk) disable iff (!rs_r) (st_r == S_CONV && pend_r == 8'h00 && oneshot_r)
      |=> odone_r && st_r == S_IDLE;
  endproperty
  a_odone: assert property (p_odone) else $error("one-shot done missing");
  property p_pdone;
    @(posedge mclk) disable iff (!rs_r) (st_r == S_CONV && pend_r == 8'h00 && !oneshot_r)
      |=> pdone_r;
  endproperty
  a_pdone: assert property (p_pdone) else $error("periodic done missing");
  property p_wait_hold;
    @(posedge mclk) disable iff (!rs_r) (st_r == S_WAIT && dcnt_r != 16'h0000 && run_r && en_r)
      |=> st_r == S_WAIT;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("delay cut short");
  property p_clr_begin;
    @(posedge mclk) disable iff (!rs_r) begin_p |=> !pdone_r;
  endproperty
  a_clr_begin: assert property (p_clr_begin) else $error("periodic done not cleared");
  property p_mask_only;
    @(posedge mclk) disable iff (!rs_r) conv_req.start |-> pend_r[conv_req.chan];
  endproperty
  a_mask_only: assert property (p_mask_only) else $error("unselected channel");
endmodule

/* verif/acs_core_model.sv */
// analog conversion core stand-in
`timescale 1ns/10ps
module acs_core_model
  import acs_pkg::*;
(
  input wire logic mclk,
  input wire acs_conv_req_t conv_req,
  input wire logic slow,
  output logic conv_done,
  output logic [RES_W-1:0] conv_data
);
  int cnt_r = 0;
  logic [2:0] ch_r = 3'h0;
  initial conv_done = 1'b0;
  initial conv_data = 10'h000;
  always @(posedge mclk)
  begin
    conv_done <= 1'b0;
    // stale data toggles so a late capture shows
    conv_data <= ~conv_data;
    if (conv_req.start)
    begin
      ch_r <= conv_req.chan;
      cnt_r <= slow ? 9 : 1;
    end
    else if (cnt_r == 1)
    begin
      cnt_r <= 0;
      conv_done <= 1'b1;
      conv_data <= {ch_r, 7'h2B} + 10'(ch_r);
    end
    else if (cnt_r > 1)
      cnt_r <= cnt_r - 1;
  end
endmodule

/* verif/adc_conversion_sequencer_tb_top.sv */
// register level tests of the converter sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module adc_conversion_sequencer_tb_top;
  import acs_pkg::*;
  localparam int TK = 4;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic slow = 1'b0;
  acs_bus_t bus = '0;
  logic [31:0] rdata;
  acs_conv_req_t conv_req;
  logic conv_done;
  logic [RES_W-1:0] conv_data;
  logic irq;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int st_cyc[$];
  int st_ch[$];
  int dn_cyc[$];
  logic [31:0] d;
  localparam logic [7:0] OFS_LIST[5] = '{OFS_CTRL, OFS_DELAY, OFS_FLAGS, OFS_ONESHOT,
    OFS_PERIODIC};
  always #5 mclk = ~mclk;
  acs_seq #(.TICK_CYCLES(TK)) acs_seq_inst (.mclk(mclk), .rst_b(rst_b), .bus(bus),
    .rdata(rdata), .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));
  acs_core_model acs_core_model_inst (.mclk(mclk), .conv_req(conv_req), .slow(slow),
    .conv_done(conv_done), .conv_data(conv_data));
  always @(posedge mclk)
  begin
    cyc++;
    if (conv_req.start === 1'b1)
    begin
      st_cyc.push_back(cyc);
      st_ch.push_back(int'(conv_req.chan));
    end
    if (conv_done === 1'b1)
      dn_cyc.push_back(cyc);
  end
  function automatic logic [31:0] res_of(input logic [2:0] c);
    return {22'h0, c, 7'h2B} + 32'(c);
  endfunction
  // one idle edge after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(posedge mclk);
  endtask
  // read data stand only in the cycle after the strobe; sampled mid-cycle
  task automatic rdw(input logic [7:0] a);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    rdw(a);
    `CHK(n, e, d)
  endtask
  task automatic wait_ctrl(input logic [31:0] m);
    int i;
    for (i = 0; i < 300; i++)
    begin
      rdw(OFS_CTRL);
      if ((d & m) !== 32'h0)
        break;
    end
    `CHK("poll_done", 1'b1, i < 300)
  endtask
  task report_and_stop;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #300000;
    errors++;
    report_and_stop;
  end
  initial
  begin
    int t0;
    int n;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    foreach (OFS_LIST[k]) rchk(OFS_LIST[k], 32'h0, "reset_val");
    wr(8'h44, 32'hFFFFFFFF);
    rchk(8'h44, 32'h0, "unmapped");
    wr(OFS_DELAY, 32'hFFFFFFFF);
    rchk(OFS_DELAY, 32'hFFFFFFFF, "delay_rw");
    wr(OFS_ONESHOT, 32'hFFFFFF05);
    rchk(OFS_ONESHOT, 32'h05, "os_mask");
    wr(OFS_IRQ_MASK, 32'h200);
    n = st_cyc.size();
    t0 = cyc;
    wr(OFS_CTRL, 32'h3);
    wait_ctrl(32'h80);
    `CHK("os_starts", 2, st_cyc.size() - n)
    `CHK("os_no_delay", 1'b1, st_cyc[n] - t0 <= 4)
    `CHK("os_ch", 2, st_ch[n + 1])
    rchk(OFS_CTRL, 32'h81, "ctrl_odone");
    rchk(OFS_FLAGS, 32'h05, "flags");
    `CHK("irq_on", 1'b1, irq)
    rchk(OFS_RES0, res_of(3'h0), "res0");
    rchk(OFS_RES0 + 8'h08, res_of(3'h2), "res2");
    wr(OFS_FLAGS, 32'h1);
    rchk(OFS_FLAGS, 32'h04, "w1c");
    wr(OFS_FLAGS, 32'h0);
    rchk(OFS_FLAGS, 32'h04, "w0");
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK("irq_masked", 1'b0, irq)
    // slow core, enable dropped mid-cycle
    slow <= 1'b1;
    wr(OFS_ONESHOT, 32'h80);
    n = st_cyc.size();
    wr(OFS_CTRL, 32'h3);
    repeat (3) @(posedge mclk);
    rchk(OFS_CTRL, 32'h01, "odone_clr");
    wr(OFS_CTRL, 32'h0);
    wait_ctrl(32'h80);
    rchk(OFS_FLAGS, 32'h84, "flags7");
    rchk(OFS_RES0 + 8'h1C, res_of(3'h7), "res7");
    wr(OFS_CTRL, 32'h2);
    repeat (20) @(posedge mclk);
    `CHK("no_start_off", 1, st_cyc.size() - n)
    slow <= 1'b0;
    wr(OFS_CTRL, 32'h80);
    wr(OFS_FLAGS, 32'hFF);
    wr(OFS_DELAY, {16'h0003, 16'h0002});
    wr(OFS_PERIODIC, 32'h42);
    wr(OFS_IRQ_MASK, 32'h100);
    n = st_cyc.size();
    t0 = cyc;
    wr(OFS_CTRL, 32'h5);
    for (int i = 0; i < 400 && st_cyc.size() < n + 6; i++) @(posedge mclk);
    wr(OFS_CTRL, 32'h1);
    repeat (60) @(posedge mclk);
    // two ticks of start delay plus write, decode and request latency
    `CHK("start_dly", 1'b1, st_cyc[n] - t0 >= 2 * TK && st_cyc[n] - t0 <= 3 * TK + 4)
    t0 = st_cyc[n + 2] - dn_cyc[n + 1];
    // three ticks of repeat delay plus done, restart and request latency
    `CHK("rpt_gap", 1'b1, t0 >= 3 * TK && t0 <= 4 * TK + 4)
    `CHK("p_ch", 1'b1, st_ch[n] == 1 && st_ch[n + 1] == 6 && st_ch[n + 2] == 1)
    `CHK("p_stop", 1'b1, (st_cyc.size() - n) % 2 == 0 && st_cyc[$] < cyc - 40)
    rchk(OFS_CTRL, 32'h41, "pdone");
    `CHK("irq_p", 1'b1, irq)
    wr(OFS_CTRL, 32'h41);
    repeat (2) @(posedge mclk);
    `CHK("irq_clr", 1'b0, irq)
    report_and_stop;
  end
endmodule
